// ===== hdl/arrs_select_result.v
// Implementation choice: the plain strobed port.
`timescale 1ns/1ps
`default_nettype none
`include "arrs_map.vh"

//Contract
// - Each finished code is stored into the result register pair.
// - Single-ended results are unsigned codes, 0x000 ground, 0x3FF top step.
// - Differential results are 10-bit two's complement, 0x200 to 0x1FF.
// - Select register at 0x7C: reference 7:6, left-justify 5, channel 4:0.
// - Reference change during conversion applies only after it completes.
// - Reference codes: external pin, analog supply, reserved, internal 1.1V.
// - Left-justify bit chooses left or right layout of the result.
// - Left-justify change alters result presentation at once.
// - Result low at 0x78, high at 0x79, layout per justify bit.
// - Channel change during conversion applies only after it completes.
// - Done flag sets when conversion finishes and result is updated.
module arrs_select_result (
    // Clock and reset
    input  wire       ref_clk,
    input  wire       rst,
    // Register port
    input  wire [7:0] reg_addr,
    input  wire [7:0] reg_wdata,
    input  wire       reg_wr,
    input  wire       reg_rd,
    output reg  [7:0] reg_rdata_q,
    // Converter core
    input  wire       conv_start,
    input  wire       conv_done,
    input  wire [9:0] conv_code,
    output reg  [1:0] core_ref_sel_q,
    output reg  [4:0] core_channel_q,
    output reg        core_diff_q,
    output reg        ref_ext_pin_q,
    output reg        ref_supply_q,
    output reg        ref_internal_q,
    // Status
    output reg        conversion_done_flag_q,
    output reg        busy_q,
    output reg        irq_q
);

    wire       busy_w;
    wire [7:0] res_low_w;
    wire [7:0] res_high_w;

    reg  [7:0] select_q;
    reg  [9:0] code_q;
    reg  [`ARRS_IRQ_W-1:0] irq_stat_q;
    reg  [`ARRS_IRQ_W-1:0] irq_en_q;
    reg  [`ARRS_IRQ_W-1:0] irq_set_d;
    reg  [`ARRS_IRQ_W-1:0] irq_clr_d;
    reg  [`ARRS_IRQ_W-1:0] irq_stat_d;
    reg  [1:0] next_ref_d;
    reg  [4:0] next_ch_d;
    reg        apply_d;

    wire [1:0] sel_ref = select_q[`ARRS_REF_HI:`ARRS_REF_LO];
    wire [4:0] sel_ch  = select_q[`ARRS_CH_HI:`ARRS_CH_LO];

    function is_diff;
        input [4:0] ch;
        begin
            is_diff = (ch >= `ARRS_CH_DIFF_BASE) && (ch < `ARRS_CH_BANDGAP);
        end
    endfunction

    arrs_conv_track u_track (
        .ref_clk    (ref_clk),
        .rst        (rst),
        .conv_start (conv_start),
        .conv_done  (conv_done),
        .busy_q     (busy_w)
    );

    // Acts on stored code at once
    arrs_result_fmt u_fmt (
        .code         (code_q),
        .left_justify (select_q[`ARRS_LJ_BIT]),
        .low_byte     (res_low_w),
        .high_byte    (res_high_w)
    );

    // Live selection passes to the core while idle and on the completing cycle
    always @* begin
        next_ref_d = core_ref_sel_q;
        next_ch_d  = core_channel_q;
        apply_d    = !busy_w || conv_done;
        if (apply_d) begin
            next_ref_d = sel_ref;
            next_ch_d  = sel_ch;
        end
    end

    always @* begin
        irq_set_d = {`ARRS_IRQ_W{1'b0}};
        irq_set_d[`ARRS_IRQ_DONE] = conv_done;
        irq_set_d[`ARRS_IRQ_REF_CHG] = apply_d && (next_ref_d != core_ref_sel_q);
        irq_clr_d = {`ARRS_IRQ_W{1'b0}};
        if (reg_wr && reg_addr == `ARRS_ADDR_IRQ_CLR) begin
            irq_clr_d = reg_wdata[`ARRS_IRQ_W-1:0];
        end
        // Set wins over a clear in the same cycle
        irq_stat_d = (irq_stat_q & ~irq_clr_d) | irq_set_d;
    end

    always @(posedge ref_clk) begin
        if (rst) begin
            select_q               <= `ARRS_SELECT_RESET;
            code_q                 <= `ARRS_CODE_ZERO;
            core_ref_sel_q         <= `ARRS_REF_EXT_PIN;
            core_channel_q         <= 5'h00;
            core_diff_q            <= 1'b0;
            ref_ext_pin_q          <= 1'b1;
            ref_supply_q           <= 1'b0;
            ref_internal_q         <= 1'b0;
            conversion_done_flag_q <= 1'b0;
            busy_q                 <= 1'b0;
            irq_stat_q             <= {`ARRS_IRQ_W{1'b0}};
            irq_en_q               <= {`ARRS_IRQ_W{1'b0}};
            irq_q                  <= 1'b0;
            reg_rdata_q            <= 8'h00;
        end else begin
            if (reg_wr && reg_addr == `ARRS_ADDR_SELECT) begin
                select_q <= reg_wdata;
            end
            if (reg_wr && reg_addr == `ARRS_ADDR_IRQ_EN) begin
                irq_en_q <= reg_wdata[`ARRS_IRQ_W-1:0];
            end
            if (conv_done) begin
                code_q <= conv_code;
            end
            if (conv_done) begin
                conversion_done_flag_q <= 1'b1;
            end else if (conv_start) begin
                conversion_done_flag_q <= 1'b0;
            end
            core_ref_sel_q <= next_ref_d;
            core_channel_q <= next_ch_d;
            core_diff_q    <= is_diff(next_ch_d);
            ref_ext_pin_q  <= (next_ref_d == `ARRS_REF_EXT_PIN);
            ref_supply_q   <= (next_ref_d == `ARRS_REF_SUPPLY);
            ref_internal_q <= (next_ref_d == `ARRS_REF_INT_1V1);
            busy_q         <= busy_w;
            irq_stat_q     <= irq_stat_d;
            irq_q          <= |(irq_stat_d & irq_en_q);
            reg_rdata_q    <= 8'h00;
            if (reg_rd) begin
                case (reg_addr)
                    `ARRS_ADDR_RES_LOW:  reg_rdata_q <= res_low_w;
                    `ARRS_ADDR_RES_HIGH: reg_rdata_q <= res_high_w;
                    `ARRS_ADDR_SELECT:   reg_rdata_q <= select_q;
                    `ARRS_ADDR_IRQ_STAT: reg_rdata_q <= {6'h00, irq_stat_q};
                    `ARRS_ADDR_IRQ_EN:   reg_rdata_q <= {6'h00, irq_en_q};
                    default:             reg_rdata_q <= 8'h00;
                endcase
            end
        end
    end

endmodule
`default_nettype wire

// ===== hdl/arrs_map.vh
`ifndef ARRS_MAP_VH
`define ARRS_MAP_VH

// Register byte addresses
`define ARRS_ADDR_RES_LOW    8'h78
`define ARRS_ADDR_RES_HIGH   8'h79
`define ARRS_ADDR_SELECT     8'h7c
`define ARRS_ADDR_IRQ_STAT   8'h80
`define ARRS_ADDR_IRQ_CLR    8'h81
`define ARRS_ADDR_IRQ_EN     8'h82

// Select register fields
`define ARRS_REF_HI          7
`define ARRS_REF_LO          6
`define ARRS_LJ_BIT          5
`define ARRS_CH_HI           4
`define ARRS_CH_LO           0
`define ARRS_SELECT_RESET    8'h00

// Reference encodings
`define ARRS_REF_EXT_PIN     2'h0
`define ARRS_REF_SUPPLY      2'h1
`define ARRS_REF_RESERVED    2'h2
`define ARRS_REF_INT_1V1     2'h3

// Channel codes from this up to, but not including, the bandgap code are differential pairs
`define ARRS_CH_DIFF_BASE    5'h10
`define ARRS_CH_BANDGAP      5'h1e
`define ARRS_CH_GROUND       5'h1f

// Status bit positions
`define ARRS_IRQ_DONE        0
`define ARRS_IRQ_REF_CHG     1
`define ARRS_IRQ_W           2

`define ARRS_CODE_ZERO       10'h000

`endif

// ===== hdl/arrs_result_fmt.v
`timescale 1ns/1ps
`default_nettype none
`include "arrs_map.vh"

// Lays a stored 10-bit code out over the low and high result bytes
module arrs_result_fmt (
    // Stored code and layout
    input  wire [9:0] code,
    input  wire       left_justify,
    // Presented bytes
    output reg  [7:0] low_byte,
    output reg  [7:0] high_byte
);

    always @* begin
        if (left_justify) begin
            high_byte = code[9:2];
            low_byte  = {code[1:0], 6'h00};
        end else begin
            high_byte = {6'h00, code[9:8]};
            low_byte  = code[7:0];
        end
    end

endmodule
`default_nettype wire

// ===== hdl/arrs_conv_track.v
`timescale 1ns/1ps
`default_nettype none
`include "arrs_map.vh"

// Tracks whether the core is busy, from its start and done pulses
module arrs_conv_track (
    // Clock and reset
    input  wire ref_clk,
    input  wire rst,
    // Core handshake
    input  wire conv_start,
    input  wire conv_done,
    // State
    output reg  busy_q
);

    always @(posedge ref_clk) begin
        if (rst) begin
            busy_q <= 1'b0;
        end else if (conv_done) begin
            busy_q <= conv_start;
        end else if (conv_start) begin
            busy_q <= 1'b1;
        end
    end

endmodule
`default_nettype wire

// ===== sim/arrs_core_model.sv
`timescale 1ns/1ps
`default_nettype none
module arrs_core_model (
    input  wire logic       ref_clk,
    output logic            conv_start,
    output logic            conv_done,
    output logic [9:0]      conv_code
);
    initial begin
        conv_start = 1'b0;
        conv_done = 1'b0;
        conv_code = 10'h2aa;
    end
    task start;
        @(posedge ref_clk) conv_start <= 1'b1;
        @(posedge ref_clk) conv_start <= 1'b0;
    endtask
    task finish(input logic [9:0] c);
        @(posedge ref_clk);
        conv_done <= 1'b1;
        conv_code <= c;
        // Stale code is inverted so a late sample shows up
        @(posedge ref_clk);
        conv_done <= 1'b0;
        conv_code <= ~c;
    endtask
endmodule
`default_nettype wire

// ===== sim/arrs_select_result_assertions.sv
`timescale 1ns/1ps
`default_nettype none
module arrs_select_result_assertions (
    input wire logic       ref_clk, rst, reg_wr, reg_rd, conv_start, conv_done,
    input wire logic [7:0] reg_addr, reg_wdata, reg_rdata_q,
    input wire logic [1:0] core_ref_sel_q,
    input wire logic [4:0] core_channel_q,
    input wire logic       core_diff_q, conversion_done_flag_q, busy_q
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (rst);
    flag_set_a: assert property (conv_done |=> conversion_done_flag_q)
        else $error("done flag not set");
    flag_clr_a: assert property (conv_start && !conv_done |=> !conversion_done_flag_q)
        else $error("done flag not cleared");
    ref_hold_a: assert property (busy_q && !conv_done && !$past(conv_done) |=> $stable(core_ref_sel_q))
        else $error("reference moved mid-conversion");
    chan_hold_a: assert property (busy_q && !conv_done && !$past(conv_done) |=> $stable(core_channel_q))
        else $error("channel moved mid-conversion");
    idle_apply_a: assert property (reg_wr && reg_addr == 8'h7c && !busy_q && !conv_start
        && !$past(conv_start) |-> ##2 core_ref_sel_q == $past(reg_wdata[7:6], 2))
        else $error("idle select not applied");
    diff_map_a: assert property (core_diff_q == (core_channel_q inside {[5'h10:5'h1d]}))
        else $error("diff flag wrong");
    busy_rise_a: assert property (conv_start |-> ##2 busy_q)
        else $error("busy late");
    rd_quiet_a: assert property (!$past(reg_rd) |-> reg_rdata_q == 8'h00)
        else $error("read data outside slot");
endmodule
`default_nettype wire

// ===== sim/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
    logic ref_clk = 0, rst = 1, reg_wr = 0, reg_rd = 0, conv_start, conv_done;
    logic [7:0] reg_addr = 0, reg_wdata = 0, reg_rdata_q, s;
    logic [9:0] conv_code, c;
    logic [1:0] core_ref_sel_q;
    logic [4:0] core_channel_q;
    logic core_diff_q, ref_ext_pin_q, ref_supply_q, ref_internal_q;
    logic conversion_done_flag_q, busy_q, irq_q;
    logic [31:0] seed = 32'h5f23;
    logic [15:0] e;
    int err_total = 0, cmp_count = 0, cyc = 0, r;
    arrs_core_model core_u (.*);
    arrs_select_result dut_u (.*);
    initial forever #25 ref_clk = ~ref_clk;
    function automatic logic [31:0] xs(input logic [31:0] x);
        x ^= x << 13;
        x ^= x >> 17;
        x ^= x << 5;
        return x;
    endfunction
    function automatic logic [15:0] lay(input logic [9:0] v, input logic lj);
        return lj ? {v, 6'h00} : {6'h00, v};
    endfunction
    task chk(input logic [7:0] g, x);
        cmp_count++;
        if (g !== x) begin
            err_total++;
            $display("mismatch %0t got %h exp %h", $time, g, x);
        end
    endtask
    task wr(input logic [7:0] a, d);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge ref_clk) reg_wr <= 1'b0;
    endtask
    task rd(input logic [7:0] a, x);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge ref_clk) reg_rd <= 1'b0;
        #1 chk(reg_rdata_q, x);
    endtask
    task close_out;
        $display("checks %0d mismatches %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    always @(posedge ref_clk) begin
        cyc++;
        if (cyc == 2000) begin
            err_total++;
            close_out;
        end
    end
    initial begin
        repeat (3) @(posedge ref_clk);
        rst <= 1'b0;
        rd(8'h7c, 8'h00);
        rd(8'h79, 8'h00);
        chk({7'h0, ref_ext_pin_q}, 8'h01);
        for (r = 0; r < 8; r++) begin
            seed = xs(seed);
            c = r == 0 ? 10'h000 : r == 1 ? 10'h3ff : r == 2 ? 10'h1ff : r == 3 ? 10'h200 : seed[9:0];
            s = {r[1:0], 1'b0, r[1] ? 5'h1b : 5'h03};
            wr(8'h7c, s);
            // Core selection follows the stored select one edge later
            @(posedge ref_clk) #1 chk({6'h0, core_ref_sel_q}, {6'h0, r[1:0]});
            chk({3'h0, core_channel_q}, {3'h0, s[4:0]});
            chk({5'h0, ref_internal_q, ref_supply_q, ref_ext_pin_q},
                {5'h0, r[1:0] == 3, r[1:0] == 1, r[1:0] == 0});
            chk({7'h0, core_diff_q}, {7'h0, r[1]});
            core_u.start;
            core_u.finish(c);
            #1 chk({7'h0, conversion_done_flag_q}, 8'h01);
            e = lay(c, 1'b0);
            rd(8'h79, e[15:8]);
            rd(8'h78, e[7:0]);
            wr(8'h7c, s | 8'h20);
            e = lay(c, 1'b1);
            rd(8'h79, e[15:8]);
            rd(8'h78, e[7:0]);
        end
        $display("layout test done");
        wr(8'h7c, 8'h00);
        core_u.start;
        wr(8'h7c, 8'he5);
        rd(8'h79, e[15:8]);
        rd(8'h78, e[7:0]);
        chk({6'h0, core_ref_sel_q}, 8'h00);
        chk({3'h0, core_channel_q}, 8'h00);
        chk({7'h0, busy_q}, 8'h01);
        core_u.finish(10'h155);
        #1 chk({6'h0, core_ref_sel_q}, 8'h03);
        chk({3'h0, core_channel_q}, 8'h05);
        rd(8'h80, 8'h03);
        $display("deferral test done");
        wr(8'h81, 8'h03);
        wr(8'h82, 8'h01);
        core_u.start;
        core_u.finish(10'h0aa);
        @(posedge ref_clk) #1 chk({7'h0, irq_q}, 8'h01);
        rd(8'h80, 8'h01);
        rd(8'h81, 8'h00);
        rd(8'h90, 8'h00);
        wr(8'h81, 8'h01);
        @(posedge ref_clk) #1 chk({7'h0, irq_q}, 8'h00);
        wr(8'h82, 8'h00);
        core_u.start;
        core_u.finish(10'h001);
        repeat (2) @(posedge ref_clk);
        #1 chk({7'h0, irq_q}, 8'h00);
        rd(8'h80, 8'h01);
        $display("interrupt test done");
        close_out;
    end
endmodule
bind arrs_select_result arrs_select_result_assertions chk_u (.*);
`default_nettype wire
